//--- common/mel_pkg.sv
/*
  mel_pkg: shared constants for the memory-controller error detail log.
  assumes: one 50 MHz core clock domain, 32-bit register port.
*/
package mel_pkg;

  // register port shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_AUX_LO  = 8'h00; // aux detail bits 31:0
  localparam logic [7:0] OFS_AUX_HI  = 8'h04; // aux detail bits 63:32
  localparam logic [7:0] OFS_STATUS  = 8'h08; // model code in 31:16
  localparam logic [7:0] OFS_BANK    = 8'h0C; // bank of last event
  localparam logic [7:0] OFS_CTRL    = 8'h10; // logging control
  localparam logic [7:0] OFS_IRQ_ST  = 8'h14; // sticky events
  localparam logic [7:0] OFS_IRQ_MSK = 8'h18; // event mask
  localparam logic [7:0] OFS_CLEAR   = 8'h1C; // write bit 0: wipe log

  // aux detail field positions
  localparam int AUX_ID_LSB   = 9;
  localparam int AUX_ID_MSB   = 13;
  localparam int AUX_M1_LSB   = 14;
  localparam int AUX_M1_MSB   = 29;
  localparam int AUX_M2_LSB   = 30;
  localparam int AUX_M2_MSB   = 45;
  localparam int AUX_R1_LSB   = 46;
  localparam int AUX_R1_MSB   = 50;
  localparam int AUX_R2_LSB   = 51;
  localparam int AUX_R2_MSB   = 55;
  localparam int AUX_RSV_LSB  = 56;
  localparam int AUX_RSV_MSB  = 61;
  localparam int AUX_V1_BIT   = 62;
  localparam int AUX_V2_BIT   = 63;

  // control and status bit positions
  localparam int CTRL_ENH_BIT = 1;  // enhanced logging enable
  localparam int CLR_BIT      = 0;
  localparam int MODEL_SPECIFIC_ERROR_CODE_LSB    = 16;
  localparam int IRQ_W        = 3;
  localparam int IRQ_WRPAR    = 0;
  localparam int IRQ_FIRST    = 1;
  localparam int IRQ_SECOND   = 2;

  // model-specific error codes
  localparam logic [15:0] MODEL_SPECIFIC_ERROR_CODE_NONE    = 16'h0000;
  localparam logic [15:0] MODEL_SPECIFIC_ERROR_CODE_WR_DATA = 16'h0002;
  localparam logic [15:0] MODEL_SPECIFIC_ERROR_CODE_WR_BE   = 16'h0004;
  localparam logic [15:0] MODEL_SPECIFIC_ERROR_CODE_RD_CORR = 16'h0080;

  // bank numbering per controller
  localparam logic [4:0] BANK_CTL0_BASE = 5'h09;
  localparam logic [4:0] BANK_CTL1_BASE = 5'h0D;
  localparam logic [4:0] BANK_RESET     = 5'h00;

  // kinds of error reported by detection logic
  typedef enum logic [1:0] {
    MEL_ERR_WR_DATA,
    MEL_ERR_WR_BE,
    MEL_ERR_RD_CORR,
    MEL_ERR_OTHER
  } mel_err_type;

endpackage

//--- common/mel_slot_if.sv
/*
  mel_slot_if: joins the log control to one erroring-device slot.
  assumes: both ends on mclk; ctl drives capture and clear.
*/
`timescale 1ns/100ps
interface mel_slot_if #(
  parameter int MASK_W = 16,
  parameter int RANK_W = 5
);
  logic              capture;  // load mask and rank
  logic              clear;    // wipe the slot
  logic [MASK_W-1:0] mask_in;  // bit mask of this event
  logic [RANK_W-1:0] rank_in;  // failing rank of this event
  logic [MASK_W-1:0] mask;     // held mask
  logic [RANK_W-1:0] rank;     // held rank
  logic              valid;    // slot holds data

  modport slot (input capture, clear, mask_in, rank_in,
                output mask, rank, valid);
  modport ctl  (output capture, clear, mask_in, rank_in,
                input mask, rank, valid);
endinterface

//--- hw/mel_dev_slot.sv
/*
  mel_dev_slot: holds mask, rank and valid of one erroring device.
  assumes: controller raises capture only with enhanced logging on.
*/
`timescale 1ns/100ps
module mel_dev_slot
  import mel_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  mel_slot_if.slot  sl
);

  logic [$bits(sl.mask)-1:0] mask_r, mask_nxt; // held bit mask
  logic [$bits(sl.rank)-1:0] rank_r, rank_nxt; // held rank
  logic                      valid_r, valid_nxt;

  // first capture sticks; later events cannot overwrite it
  always_comb begin
    mask_nxt  = mask_r;
    rank_nxt  = rank_r;
    valid_nxt = valid_r;
    if (sl.capture && !valid_r) begin  // a capture into an empty slot beats clear
      mask_nxt  = sl.mask_in;
      rank_nxt  = sl.rank_in;
      valid_nxt = 1'b1;
    end else if (sl.clear) begin
      mask_nxt  = '0;
      rank_nxt  = '0;
      valid_nxt = 1'b0;
    end
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r  <= '0;
      rank_r  <= '0;
      valid_r <= 1'b0;
    end else if (clk_en) begin
      mask_r  <= mask_nxt;
      rank_r  <= rank_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign sl.mask  = mask_r;
  assign sl.rank  = rank_r;
  assign sl.valid = valid_r;

endmodule

//--- hw/mel_error_log.sv
/*
  mel_error_log: fills the 64-bit aux detail register of a memory
  controller error bank and its companion code, bank and interrupt.
  assumes: one error event per cycle from detection logic, register
  port strobes one cycle long, read data valid the cycle after.
*/
// Chosen here: the register offsets and the strobed register port.
// Behaviour
// - write parity error logs buffer id 13:9
// - second correctable read logs device id there
// - enhanced: first device mask in 29:14
// - enhanced: second device mask in 45:30
// - enhanced: first device rank in 50:46
// - enhanced: second device rank in 55:51
// - enhanced: bit 62 marks first device valid
// - enhanced: bit 63 marks second device valid
// - control bit 1 enables enhanced logging
// - status code 002h data, 004h enable parity
// - controller 0 banks 9-12, controller 1 13-16
`timescale 1ns/100ps
module mel_error_log
  import mel_pkg::*;
#(
  parameter int MASK_W = 16,
  parameter int RANK_W = 5,
  parameter int ID_W   = 5
)(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              err_valid,
  input  mel_err_type            err_type,
  input  wire logic              err_ctrl_sel,
  input  wire logic [1:0]        err_channel,
  input  wire logic [ID_W-1:0]   err_wdb_id,
  input  wire logic [ID_W-1:0]   err_dev_id,
  input  wire logic [MASK_W-1:0] err_bit_mask,
  input  wire logic [RANK_W-1:0] err_rank,
  output logic                   irq
);

  // slot links for first and second erroring device
  mel_slot_if #(.MASK_W(MASK_W), .RANK_W(RANK_W)) s1 ();
  mel_slot_if #(.MASK_W(MASK_W), .RANK_W(RANK_W)) s2 ();

  mel_dev_slot u_first (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .sl      (s1)
  );

  mel_dev_slot u_second (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .sl      (s2)
  );

  // state
  logic              enh_r, enh_nxt;         // enhanced logging on
  logic [ID_W-1:0]   id_r, id_nxt;           // aux bits 13:9
  logic [15:0]       model_specific_error_code_r, model_specific_error_code_nxt;     // companion code
  logic [4:0]        bank_r, bank_nxt;       // bank of last event
  logic              seen_rd_r, seen_rd_nxt; // a read error came
  logic              sec_rd_r, sec_rd_nxt;   // second one logged
  logic [IRQ_W-1:0]  ist_r, ist_nxt;         // sticky events
  logic [IRQ_W-1:0]  imsk_r, imsk_nxt;       // event mask
  logic [DATA_W-1:0] rdata_r, rdata_nxt;     // read answer

  // decoded events and strobes
  logic             ev;        // event taken this cycle
  logic             wr_par;    // either write parity kind
  logic             rd_corr;   // correctable read error
  logic             cap1;      // first device capture
  logic             cap2;      // second device capture
  logic             sec_id;    // log second device id
  logic             wr_ctrl;   // control write
  logic             log_clr;   // software wipe of the log
  logic             rd_ist;    // status read, clears it
  logic [IRQ_W-1:0] ev_bits;   // events into sticky bits
  logic [63:0]      aux_w;     // assembled aux detail word

  assign ev      = clk_en && err_valid;
  assign wr_par  = ev && (err_type == MEL_ERR_WR_DATA ||
                          err_type == MEL_ERR_WR_BE);
  assign rd_corr = ev && err_type == MEL_ERR_RD_CORR;
  // capture only when enhanced logging is enabled
  assign cap1    = rd_corr && enh_r && !s1.valid;
  // a wipe empties the first slot, so no second may land with it
  assign cap2    = rd_corr && enh_r && s1.valid
                   && !s2.valid && !log_clr;
  // parity id has the field when both arrive at once
  assign sec_id  = rd_corr && seen_rd_r && !sec_rd_r && !wr_par;
  assign wr_ctrl = clk_en && reg_wr && reg_addr == OFS_CTRL;
  assign log_clr = clk_en && reg_wr && reg_addr == OFS_CLEAR
                   && reg_wdata[CLR_BIT];
  assign rd_ist  = clk_en && reg_rd && reg_addr == OFS_IRQ_ST;

  // slot drive: a disabled log is held wiped
  always_comb begin
    s1.capture = cap1;
    s1.mask_in = err_bit_mask;
    s1.rank_in = err_rank;
    s1.clear   = log_clr || !enh_r;
    s2.capture = cap2;
    s2.mask_in = err_bit_mask;
    s2.rank_in = err_rank;
    s2.clear   = log_clr || !enh_r;
  end

  // aux word; reserved and address-info bits read zero
  always_comb begin
    aux_w = '0;
    aux_w[AUX_ID_MSB:AUX_ID_LSB] = id_r;
    aux_w[AUX_M1_MSB:AUX_M1_LSB] = s1.mask;
    aux_w[AUX_M2_MSB:AUX_M2_LSB] = s2.mask;
    aux_w[AUX_R1_MSB:AUX_R1_LSB] = s1.rank;
    aux_w[AUX_R2_MSB:AUX_R2_LSB] = s2.rank;
    aux_w[AUX_V1_BIT]            = s1.valid;
    aux_w[AUX_V2_BIT]            = s2.valid;
  end

  // next values of the log state
  always_comb begin
    enh_nxt     = enh_r;
    id_nxt      = id_r;
    model_specific_error_code_nxt   = model_specific_error_code_r;
    bank_nxt    = bank_r;
    seen_rd_nxt = seen_rd_r;
    sec_rd_nxt  = sec_rd_r;
    imsk_nxt    = imsk_r;
    if (wr_ctrl) begin
      enh_nxt = reg_wdata[CTRL_ENH_BIT];
    end
    if (reg_wr && clk_en && reg_addr == OFS_IRQ_MSK) begin
      imsk_nxt = reg_wdata[IRQ_W-1:0];
    end
    if (log_clr) begin
      id_nxt      = '0;
      model_specific_error_code_nxt   = MODEL_SPECIFIC_ERROR_CODE_NONE;
      bank_nxt    = BANK_RESET;
      seen_rd_nxt = 1'b0;
      sec_rd_nxt  = 1'b0;
    end
    // new events override a same-cycle wipe
    if (ev) begin
      bank_nxt = (err_ctrl_sel ? BANK_CTL1_BASE : BANK_CTL0_BASE)
                 + {3'b000, err_channel};
    end
    if (wr_par) begin
      id_nxt    = err_wdb_id;
      model_specific_error_code_nxt = (err_type == MEL_ERR_WR_DATA) ?
                  MODEL_SPECIFIC_ERROR_CODE_WR_DATA : MODEL_SPECIFIC_ERROR_CODE_WR_BE;
    end else if (rd_corr) begin
      seen_rd_nxt = 1'b1;
      if (enh_r) begin
        model_specific_error_code_nxt = MODEL_SPECIFIC_ERROR_CODE_RD_CORR;
      end
      if (sec_id) begin
        id_nxt     = err_dev_id;
        sec_rd_nxt = 1'b1;
      end
    end
  end

  // sticky interrupt status; a new event beats the read clear
  always_comb begin
    ev_bits             = '0;
    ev_bits[IRQ_WRPAR]  = wr_par;
    ev_bits[IRQ_FIRST]  = cap1;
    ev_bits[IRQ_SECOND] = cap2;
    ist_nxt = (rd_ist ? '0 : ist_r) | ev_bits;
  end

  // read answer, present only in the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_AUX_LO:  rdata_nxt = aux_w[31:0];
        OFS_AUX_HI:  rdata_nxt = aux_w[63:32];
        OFS_STATUS:  rdata_nxt = {model_specific_error_code_r, 16'h0000};
        OFS_BANK:    rdata_nxt = {27'h000_0000, bank_r};
        OFS_CTRL:    rdata_nxt = {30'h0000_0000, enh_r, 1'b0};
        OFS_IRQ_ST:  rdata_nxt = {29'h0000_0000, ist_r};
        OFS_IRQ_MSK: rdata_nxt = {29'h0000_0000, imsk_r};
        default:     rdata_nxt = '0;  // unmapped, also clear
      endcase
    end
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enh_r     <= 1'b0;
      id_r      <= '0;
      model_specific_error_code_r   <= MODEL_SPECIFIC_ERROR_CODE_NONE;
      bank_r    <= BANK_RESET;
      seen_rd_r <= 1'b0;
      sec_rd_r  <= 1'b0;
      ist_r     <= '0;
      imsk_r    <= '0;
      rdata_r   <= '0;
    end else if (clk_en) begin
      enh_r     <= enh_nxt;
      id_r      <= id_nxt;
      model_specific_error_code_r   <= model_specific_error_code_nxt;
      bank_r    <= bank_nxt;
      seen_rd_r <= seen_rd_nxt;
      sec_rd_r  <= sec_rd_nxt;
      ist_r     <= ist_nxt;
      imsk_r    <= imsk_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  // level interrupt while any unmasked event is pending
  assign irq       = |(ist_r & imsk_r);

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // a read error seen first, then bit 62 reads back set
  sequence seq_first_logged;
    cap1 ##1 aux_w[AUX_V1_BIT];
  endsequence

  // status read with no new event in the same cycle
  sequence seq_status_read;
    rd_ist && ev_bits == '0;
  endsequence

  chk_wdb_id_log: assert property (
    wr_par |=> id_r == $past(err_wdb_id))
    else $error("write buffer id not logged");

  chk_second_dev_id: assert property (
    sec_id |=> id_r == $past(err_dev_id))
    else $error("second device id not logged");

  chk_first_mask: assert property (
    cap1 |=> aux_w[AUX_M1_MSB:AUX_M1_LSB] == $past(err_bit_mask))
    else $error("first device mask wrong");

  chk_second_mask: assert property (
    cap2 |=> aux_w[AUX_M2_MSB:AUX_M2_LSB] == $past(err_bit_mask))
    else $error("second device mask wrong");

  chk_first_rank: assert property (
    cap1 |=> aux_w[AUX_R1_MSB:AUX_R1_LSB] == $past(err_rank))
    else $error("first device rank wrong");

  chk_second_rank: assert property (
    cap2 |=> aux_w[AUX_R2_MSB:AUX_R2_LSB] == $past(err_rank))
    else $error("second device rank wrong");

  chk_first_valid_bit: assert property (
    cap1 |-> seq_first_logged ##0 ist_r[IRQ_FIRST])
    else $error("first valid flag missing");

  chk_second_after_first: assert property (
    $rose(aux_w[AUX_V2_BIT]) |-> $past(aux_w[AUX_V1_BIT])
      && aux_w[AUX_V1_BIT])
    else $error("second valid without first");

  chk_enh_control: assert property (
    wr_ctrl |=> enh_r == $past(reg_wdata[CTRL_ENH_BIT]))
    else $error("enhanced enable not taken");

  chk_wr_code: assert property (
    wr_par && err_type == MEL_ERR_WR_BE |=> model_specific_error_code_r == MODEL_SPECIFIC_ERROR_CODE_WR_BE)
    else $error("byte enable parity code wrong");

  chk_bank_range: assert property (
    ev && !err_ctrl_sel |=> bank_r >= BANK_CTL0_BASE
      && bank_r < BANK_CTL1_BASE)
    else $error("controller 0 bank out of range");

  chk_disabled_zero: assert property (
    !enh_r && clk_en |=> aux_w[AUX_V2_BIT:AUX_M1_LSB] == '0)
    else $error("detail fields not zero when disabled");

  chk_status_clear: assert property (
    seq_status_read ##0 clk_en |=> ist_r == '0 ##1 1'b1)
    else $error("status read did not clear");

  // read data stand one cycle only, then fall back to zero
  chk_read_idle: assert property (
    clk_en && !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");

  // a low enable must hold the aux word, read data and sticky status still
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(aux_w) && $stable(reg_rdata) && $stable(ist_r))
    else $error("state moved while frozen");

  // a wipe with no event clears the id and the code
  chk_wipe_log: assert property (
    log_clr && !ev |=> id_r == '0 && model_specific_error_code_r == MODEL_SPECIFIC_ERROR_CODE_NONE)
    else $error("log wipe incomplete");

endmodule

//--- bench/mel_error_log_tb_top.sv
/*
  mel_error_log_tb_top: self-checking bench for the error detail log.
  assumes: mel_pkg compiled first, design on one 50 MHz mclk,
  register port answers one cycle after the read strobe.
*/
`timescale 1ns/100ps
module mel_error_log_tb_top
  import mel_pkg::*;
();
  logic              mclk;         // core clock
  logic              reset_n;      // async reset, low active
  logic              clk_en;       // run enable
  logic [ADDR_W-1:0] reg_addr;     // register byte address
  logic [DATA_W-1:0] reg_wdata;    // register write data
  logic              reg_wr;       // write strobe
  logic              reg_rd;       // read strobe
  logic [DATA_W-1:0] reg_rdata;    // read answer
  logic              err_valid;    // error event pulse
  mel_err_type       err_type;     // kind of error
  logic              err_ctrl_sel; // controller select
  logic [1:0]        err_channel;  // channel in controller
  logic [4:0]        err_wdb_id;   // buffer id
  logic [4:0]        err_dev_id;   // device id
  logic [15:0]       err_bit_mask; // device bit mask
  logic [4:0]        err_rank;     // failing rank
  logic              irq;          // level interrupt
  int                num_errors;   // mismatches seen
  int                check_count;  // comparisons made
  logic [31:0]       rd_v;         // last read word
  logic [63:0]       aux_v;        // last 64-bit aux read

  mel_error_log uut (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .err_valid    (err_valid),
    .err_type     (err_type),
    .err_ctrl_sel (err_ctrl_sel),
    .err_channel  (err_channel),
    .err_wdb_id   (err_wdb_id),
    .err_dev_id   (err_dev_id),
    .err_bit_mask (err_bit_mask),
    .err_rank     (err_rank),
    .irq          (irq)
  );

  // free-running clock, 20 ns period
  always #10 mclk = ~mclk;

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one-cycle write strobe; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  // two halves are not latched together, so no event in between
  task automatic rd_aux;
    rd(OFS_AUX_LO);
    aux_v[31:0] = rd_v;
    rd(OFS_AUX_HI);
    aux_v[63:32] = rd_v;
  endtask

  task automatic ev(input mel_err_type t, input logic s,
                    input logic [1:0] c, input logic [4:0] w,
                    input logic [4:0] d, input logic [15:0] m,
                    input logic [4:0] r);
    @(posedge mclk);
    err_valid    <= 1'b1;
    err_type     <= t;
    err_ctrl_sel <= s;
    err_channel  <= c;
    err_wdb_id   <= w;
    err_dev_id   <= d;
    err_bit_mask <= m;
    err_rank     <= r;
    @(posedge mclk);
    err_valid    <= 1'b0;
    #1;
  endtask

  // expected aux word built field by field
  function automatic logic [63:0] mk(
      input logic [4:0] id, input logic [15:0] m1,
      input logic [15:0] m2, input logic [4:0] r1,
      input logic [4:0] r2, input logic v1, input logic v2);
    logic [63:0] e;
    e = '0;
    e[AUX_ID_MSB:AUX_ID_LSB] = id;
    e[AUX_M1_MSB:AUX_M1_LSB] = m1;
    e[AUX_M2_MSB:AUX_M2_LSB] = m2;
    e[AUX_R1_MSB:AUX_R1_LSB] = r1;
    e[AUX_R2_MSB:AUX_R2_LSB] = r2;
    e[AUX_V1_BIT] = v1;
    e[AUX_V2_BIT] = v2;
    return e;
  endfunction

  // reset state, read-only aux and an unmapped address
  task automatic t_reset;
    wr(OFS_AUX_LO, 32'hFFFF_FFFF);
    rd_aux;
    chk("aux_rst", aux_v, 64'h0);
    rd(8'h20);
    chk("unmapped", rd_v, 64'h0);
    rd(OFS_CTRL);
    chk("ctrl_rst", rd_v, 64'h0);
  endtask

  // write parity with logging off: id, code, bank, event bit
  task automatic wrpar(input mel_err_type t, input logic s,
                       input logic [1:0] c, input logic [4:0] id,
                       input logic [15:0] code);
    logic [4:0] bank;
    bank = (s ? BANK_CTL1_BASE : BANK_CTL0_BASE) + 5'(c);
    ev(t, s, c, id, 5'h00, 16'hFFFF, 5'h1F);
    rd_aux;
    chk("aux_id", aux_v, mk(id, '0, '0, '0, '0, 1'b0, 1'b0));
    rd(OFS_STATUS);
    chk("code", rd_v, {32'h0, code, 16'h0000});
    rd(OFS_BANK);
    chk("bank", rd_v, {59'h0, bank});
    rd(OFS_IRQ_ST);
    chk("irq_st", rd_v, 64'h1);
  endtask

  // masked, unmasked and read-cleared interrupt
  task automatic t_irq;
    ev(MEL_ERR_WR_DATA, 1'b0, 2'd1, 5'h03, 5'h00, 16'h0000, 5'h00);
    chk("irq_masked", irq, 1'b0);
    wr(OFS_IRQ_MSK, 32'h0000_0007);
    chk("irq_on", irq, 1'b1);
    rd(OFS_IRQ_ST);
    chk("irq_st", rd_v, 64'h1);
    chk("irq_off", irq, 1'b0);
    wr(OFS_IRQ_MSK, 32'h0000_0000);
  endtask

  // correctable read with logging off leaves detail fields zero
  task automatic t_off;
    wr(OFS_CLEAR, 32'h0000_0001);
    ev(MEL_ERR_RD_CORR, 1'b0, 2'd1, 5'h00, 5'h04, 16'hBEEF, 5'h13);
    rd_aux;
    chk("aux_off", aux_v, 64'h0);
    rd(OFS_IRQ_ST);
    chk("irq_none", rd_v, 64'h0);
  endtask

  // two devices logged, a third refused, then disable wipes
  task automatic t_enh;
    wr(OFS_CLEAR, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0002);
    rd(OFS_CTRL);
    chk("ctrl", rd_v, 64'h2);
    ev(MEL_ERR_RD_CORR, 1'b1, 2'd0, 5'h00, 5'h07, 16'hA5C3, 5'h11);
    rd_aux;
    chk("aux_1st", aux_v,
        mk('0, 16'hA5C3, '0, 5'h11, '0, 1'b1, 1'b0));
    rd(OFS_STATUS);
    chk("code_rd", rd_v, {32'h0, MODEL_SPECIFIC_ERROR_CODE_RD_CORR, 16'h0000});
    ev(MEL_ERR_RD_CORR, 1'b1, 2'd0, 5'h00, 5'h1B, 16'h3C5A, 5'h0E);
    // a third device must not disturb the held pair
    ev(MEL_ERR_RD_CORR, 1'b1, 2'd0, 5'h00, 5'h02, 16'hFFFF, 5'h1F);
    rd_aux;
    chk("aux_2nd", aux_v,
        mk(5'h1B, 16'hA5C3, 16'h3C5A, 5'h11, 5'h0E, 1'b1, 1'b1));
    rd(OFS_BANK);
    chk("bank_rd", rd_v, 64'hD);
    rd(OFS_IRQ_ST);
    chk("irq_dev", rd_v, 64'h6);
    wr(OFS_CTRL, 32'h0000_0000);
    rd_aux;
    // disable wipes masks, ranks and valids; the id stays
    chk("aux_dis", aux_v, mk(5'h1B, '0, '0, '0, '0, 1'b0, 1'b0));
  endtask

  // low enable ignores strobes and events; other errors move bank only
  task automatic t_freeze;
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0002);
    ev(MEL_ERR_RD_CORR, 1'b0, 2'd2, 5'h00, 5'h05, 16'h1234, 5'h03);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl_frz", rd_v, 64'h0);
    rd(OFS_BANK);
    chk("bank_frz", rd_v, 64'hD);
    ev(MEL_ERR_OTHER, 1'b0, 2'd3, 5'h00, 5'h05, 16'h1234, 5'h03);
    rd(OFS_BANK);
    chk("bank_oth", rd_v, 64'hC);
    rd_aux;
    chk("aux_frz", aux_v, mk(5'h1B, '0, '0, '0, '0, 1'b0, 1'b0));
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_valid = 1'b0;
    err_type = MEL_ERR_OTHER;
    err_ctrl_sel = 1'b0;
    err_channel = 2'd0;
    err_wdb_id = '0;
    err_dev_id = '0;
    err_bit_mask = '0;
    err_rank = '0;
    num_errors = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    wrpar(MEL_ERR_WR_DATA, 1'b0, 2'd2, 5'h15, MODEL_SPECIFIC_ERROR_CODE_WR_DATA);
    wrpar(MEL_ERR_WR_BE, 1'b1, 2'd3, 5'h0A, MODEL_SPECIFIC_ERROR_CODE_WR_BE);
    wrpar(MEL_ERR_WR_DATA, 1'b1, 2'd0, 5'h1F, MODEL_SPECIFIC_ERROR_CODE_WR_DATA);
    wrpar(MEL_ERR_WR_BE, 1'b0, 2'd0, 5'h01, MODEL_SPECIFIC_ERROR_CODE_WR_BE);
    t_irq;
    t_off;
    t_enh;
    t_freeze;
    report_and_stop;
  end

  // hang guard, far beyond the about 140 cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    report_and_stop;
  end
endmodule
